// >>> bench/cfg_loader_monitor.sv
// assertions on the loader's memory, image and register bus ports
module cfg_loader_monitor
  import cfg_loader_pkg::*;
(
  input wire logic clk, resetn, mem_rd_req, mem_rd_valid, host_cfg_enable,
  input wire logic [MEM_ADDR_W-1:0] mem_rd_addr,
  input wire logic [WORD_W-1:0] mem_rd_data,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [31:0] cfg_p2_7c, cfg_p2_90, cfg_p2_f0, cfg_p2_78, cfg_p2_8c,
  input wire logic [31:0] cfg_p0_d0, cfg_p0_144, cfg_p0_cc, cfg_p0_154,
  input wire logic [NUM_PORTS*32-1:0] cfg_pm_cap, cfg_pm_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic [WORD_W-1:0] d_q;
  logic [1:0] p_q;
  assign take = mem_rd_req && mem_rd_valid;
  // word and port of the latest take; images follow two edges after it
  always_ff @(posedge clk)
  begin
    if (take)
    begin
      d_q <= mem_rd_data;
      p_q <= mem_rd_addr[2:1];
    end
  end
  AST_HOLD: assert property (mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("word request dropped or moved before its answer");
  AST_ORDER: assert property (take && mem_rd_addr == 8'h44 |=> mem_rd_addr == 8'h50)
    else $error("second word address wrong");
  AST_PHY: assert property (take && mem_rd_addr == 8'h44 |-> ##2
    cfg_p2_7c[12:8] == d_q[4:0] && cfg_p2_90[6:0] == d_q[11:5])
    else $error("phy parameter images wrong");
  AST_LANE: assert property (take && mem_rd_addr == 8'h44 |-> ##2
    cfg_p2_f0[6] == d_q[12] && cfg_p2_78[11] == d_q[13] && cfg_p2_8c[9:8] == d_q[15:14])
    else $error("port 2 lane control images wrong");
  AST_PM_CAP: assert property (take && mem_rd_addr inside {8'h50, 8'h52, 8'h54}
    |-> ##2 cfg_pm_cap[p_q*32+22 +: 8] == {d_q[7:6], 1'b0, d_q[5:1]}
    && cfg_pm_data[p_q*32+3] == d_q[0])
    else $error("power capability image wrong");
  AST_PM_DATA: assert property (take && mem_rd_addr inside {8'h51, 8'h53, 8'h55} |-> ##2
    cfg_pm_data[p_q*32+24 +: 8] == d_q[15:8])
    else $error("power data image wrong");
  AST_MISC: assert property (take && mem_rd_addr == 8'h60 |-> ##2
    cfg_p0_d0[28] == d_q[1] && cfg_pm_cap[21] == d_q[2] && cfg_p0_144[4] == d_q[3]
    && cfg_p0_cc[26:24] == d_q[6:4] && cfg_p0_154[7:1] == d_q[15:9])
    else $error("port 0 misc images wrong");
  AST_ENABLE: assert property (take && mem_rd_addr == 8'h60 |-> ##3 host_cfg_enable)
    else $error("host access not enabled after last word");
  AST_LOCK: assert property (mem_rd_req [*3] |-> !host_cfg_enable)
    else $error("host access enabled during load");
  AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule

bind eeprom_config_field_loader cfg_loader_monitor mon (.*);

// >>> bench/cfg_mem_model.sv
// configuration memory model answering word reads promptly or slowly
module cfg_mem_model
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic [NUM_WORDS*WORD_W-1:0] words,
  input wire logic mem_rd_req,
  input wire logic [MEM_ADDR_W-1:0] mem_rd_addr,
  output logic [WORD_W-1:0] mem_rd_data,
  output logic mem_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  logic [WORD_W-1:0] word_sel;
  // one 16-bit word per address
  always_comb
  begin
    word_sel = ~mem_rd_data;
    for (int i = 0; i < NUM_WORDS; i++)
      if (WORD_ADDR_LIST[i*8 +: 8] == mem_rd_addr) word_sel = words[i*WORD_W +: WORD_W];
  end
  // data lines toggle while no word is requested and after each answer; they hold while a slow answer waits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 16'h0000;
      wait_q <= 3'h0;
    end
    else if (mem_rd_valid || !mem_rd_req)
    begin
      mem_rd_valid <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      wait_q <= slow ? 3'($urandom_range(4, 1)) : 3'h0;
    end
    else if (wait_q != 3'h0)
      wait_q <= wait_q - 3'h1;
    else
    begin
      mem_rd_valid <= 1'b1;
      mem_rd_data <= word_sel;
    end
  end
endmodule

// >>> bench/test_eeprom_config_field_loader.sv
// self-checking bench for the configuration field loader
module test_eeprom_config_field_loader
  import cfg_loader_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RLIST [15] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
    8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h40, 8'h44, 8'h48};
  logic clk, resetn, slow, mem_rd_req, mem_rd_valid, host_cfg_enable;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, cfg_p2_7c, cfg_p2_90, cfg_p2_f0, cfg_p2_78;
  logic [31:0] cfg_p2_8c, cfg_p0_d0, cfg_p0_144, cfg_p0_cc, cfg_p0_154;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [MEM_ADDR_W-1:0] mem_rd_addr;
  logic [WORD_W-1:0] mem_rd_data;
  logic [NUM_PORTS*32-1:0] cfg_pm_cap, cfg_pm_data;
  logic [NUM_WORDS*WORD_W-1:0] words;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  eeprom_config_field_loader dut (.*);
  cfg_mem_model mem (.*);

  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    logic [15:0] a0, a7, pc, pd;
    int p;
    p = int'(a[3:2]);
    a0 = words[15:0];
    a7 = words[127:112];
    pc = words[(1 + 2 * p) * 16 +: 16];
    pd = words[(2 + 2 * p) * 16 +: 16];
    case (a)
      8'h08: return {19'h0, a0[4:0], 8'h00};
      8'h0C: return {25'h0, a0[11:5]};
      8'h10: return {25'h0, a0[12], 6'h00};
      8'h14: return {20'h0, a0[13], 11'h000};
      8'h18: return {22'h0, a0[15:14], 8'h00};
      8'h1C: return {3'h0, a7[1], 28'h000_0000};
      8'h20: return {27'h0, a7[3], 4'h0};
      8'h24: return {5'h0, a7[6:4], 24'h00_0000};
      8'h28: return {24'h0, a7[15:9], 1'b0};
      8'h30, 8'h34, 8'h38: return {2'h0, pc[7:6], 1'b0, pc[5:1], p == 0 && a7[2], 21'h0};
      8'h40, 8'h44, 8'h48: return {pd[15:8], 20'h0, pc[0], 3'h0};
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  // handshakes are judged on settled values mid-cycle, acted on at the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end
    while (!b_go);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar_go, r_go;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_go) s_axi_arvalid <= 1'b0;
    end
    while (!r_go);
    s_axi_rready <= 1'b0;
  endtask

  task automatic test_done();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      test_done();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(64));
    {resetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    words = {$urandom, $urandom, $urandom, $urandom};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int pass = 0; pass < 4; pass++)
    begin
      if (pass > 0)
      begin
        @(posedge clk);
        slow <= 1'b1;
        words <= pass == 1 ? '1 : pass == 2 ? '0 : {$urandom, $urandom, $urandom, $urandom};
        axi_wr(REG_CTRL, 32'h0000_0001);
        chk("reload resp", 32'(RESP_OKAY), 32'(resp));
      end
      if (pass == 3)
      begin
        repeat (3) @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
      end
      for (int i = 0; i < 100 && host_cfg_enable; i++) @(posedge clk);
      for (int i = 0; i < 400 && !host_cfg_enable; i++) @(posedge clk);
      chk("loaded", 32'h1, 32'(host_cfg_enable));
      foreach (RLIST[i])
      begin
        axi_rd(RLIST[i]);
        chk("image", exp_reg(RLIST[i]), rd);
        chk("image resp", 32'(RESP_OKAY), 32'(resp));
      end
      chk("port2 data", exp_reg(8'h48), cfg_pm_data[95:64]);
      chk("port1 cap", exp_reg(8'h34), cfg_pm_cap[63:32]);
      axi_rd(REG_STATUS);
      chk("status", 32'h0000_0802, rd);
    end
    axi_wr(REG_P2_7C, $urandom);
    chk("ro write resp", 32'(RESP_OKAY), 32'(resp));
    axi_rd(REG_P2_7C);
    chk("ro keep", exp_reg(REG_P2_7C), rd);
    axi_rd(8'hFC);
    chk("unmapped resp", 32'(RESP_DECERR), 32'(resp));
    chk("unmapped data", 32'h0000_0000, rd);
    axi_wr(8'hFC, 32'h0000_0001);
    chk("unmapped wr", 32'(RESP_DECERR), 32'(resp));
    s_axi_wstrb <= 4'hE;
    axi_wr(REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("reload without strobe", 32'h1, 32'(host_cfg_enable));
    test_done();
  end
endmodule

// >>> pkg/cfg_loader_if.sv
// carriers between the loader top, its word fetcher and its register slave
interface reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

interface word_if;
  logic start;
  logic busy;
  logic done;
  logic word_valid;
  logic [2:0] word_idx;
  logic [15:0] word_data;
  modport fetch(input start, output busy, done, word_valid, word_idx, word_data);
  modport sink(output start, input busy, done, word_valid, word_idx, word_data);
endinterface

// >>> pkg/cfg_loader_pkg.sv
// constants shared by the configuration word loader and its register slave
package cfg_loader_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_PORTS = 3;
  localparam int NUM_WORDS = 8;
  localparam int WORD_W = 16;
  localparam int MEM_ADDR_W = 8;
  localparam int IDX_W = 3;
  localparam int AXI_ADDR_W = 8;
  localparam int CNT_W = 4;

  // ****************************************
  // memory words fetched, index 0 first
  // ****************************************
  // addresses 44h, 50h, 51h, 52h, 53h, 54h, 55h, 60h
  localparam logic [63:0] WORD_ADDR_LIST = 64'h6055_5453_5251_5044;
  localparam logic [IDX_W-1:0] IDX_PHY = 3'h0;
  localparam int IDX_PM_BASE = 1;
  localparam logic [IDX_W-1:0] IDX_P0_MISC = 3'h7;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // ****************************************
  // field positions: source lsb, width, destination lsb
  // ****************************************
  localparam int PHY2_SRC = 0, PHY2_W = 5, PHY2_DST = 8;
  localparam int PHY3_SRC = 5, PHY3_W = 7, PHY3_DST = 0;
  localparam int DEEMPH_SRC = 12, DEEMPH_W = 1, DEEMPH_DST = 6;
  localparam int COMPL_SRC = 13, COMPL_W = 1, COMPL_DST = 11;
  localparam int DCNT_SRC = 14, DCNT_W = 2, DCNT_DST = 8;
  localparam int NOSR_SRC = 0, NOSR_W = 1, NOSR_DST = 3;
  localparam int AUX_SRC = 1, AUX_W = 3, AUX_DST = 22;
  localparam int D1_SRC = 4, D1_W = 1, D1_DST = 25;
  localparam int D2_SRC = 5, D2_W = 1, D2_DST = 26;
  localparam int PME_SRC = 6, PME_W = 2, PME_DST = 28;
  localparam int PMDATA_SRC = 8, PMDATA_W = 8, PMDATA_DST = 24;
  localparam int SLOTCLK_SRC = 1, SLOTCLK_W = 1, SLOTCLK_DST = 28;
  localparam int DSI_SRC = 2, DSI_W = 1, DSI_DST = 21;
  localparam int LPVC_SRC = 3, LPVC_W = 1, LPVC_DST = 4;
  localparam int PORTNUM_SRC = 4, PORTNUM_W = 3, PORTNUM_DST = 24;
  localparam int TCMAP_SRC = 9, TCMAP_W = 7, TCMAP_DST = 1;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_P2_7C = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_P2_90 = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] REG_P2_F0 = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_P2_78 = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] REG_P2_8C = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] REG_P0_D0 = 8'h1C;
  localparam logic [AXI_ADDR_W-1:0] REG_P0_144 = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] REG_P0_CC = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] REG_P0_154 = 8'h28;
  localparam logic [AXI_ADDR_W-1:0] REG_PM_CAP_BASE = 8'h30;
  localparam logic [AXI_ADDR_W-1:0] REG_PM_DATA_BASE = 8'h40;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // place a field of a memory word at its configuration bit position
  function automatic logic [31:0] fld(input logic [WORD_W-1:0] w, input int src,
                                      input int wid, input int dst);
    logic [WORD_W-1:0] m;
    m = (w >> src) & ((16'h0001 << wid) - 16'h0001);
    fld = 32'(m) << dst;
  endfunction

endpackage

// >>> verilog/axil_regs_slave.sv
// axi4-lite slave that forwards single accesses to the register file
module axil_regs_slave
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  reg_if.bus rb
);

  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, ar_take;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign ar_take = s_axi_arvalid && !rvalid_q;
  assign rb.wr_en = do_write;
  assign rb.wr_addr = awaddr_q;
  assign rb.wr_data = wdata_q;
  assign rb.wr_strb = wstrb_q;
  assign rb.rd_addr = s_axi_araddr;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else
    begin
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= rb.wr_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= rb.rd_ok ? RESP_OKAY : RESP_DECERR;
        rdata_q <= rb.rd_ok ? rb.rd_data : 32'h0000_0000;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

endmodule

// >>> verilog/eeprom_config_field_loader.sv
// configuration memory field loader for words 44h to 60h of a three-port switch
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
module eeprom_config_field_loader
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_rd_req,
  output logic [MEM_ADDR_W-1:0] mem_rd_addr,
  input wire logic [WORD_W-1:0] mem_rd_data,
  input wire logic mem_rd_valid,
  output logic host_cfg_enable,
  output logic [31:0] cfg_p2_7c,
  output logic [31:0] cfg_p2_90,
  output logic [31:0] cfg_p2_f0,
  output logic [31:0] cfg_p2_78,
  output logic [31:0] cfg_p2_8c,
  output logic [31:0] cfg_p0_d0,
  output logic [31:0] cfg_p0_144,
  output logic [31:0] cfg_p0_cc,
  output logic [31:0] cfg_p0_154,
  output logic [NUM_PORTS*32-1:0] cfg_pm_cap,
  output logic [NUM_PORTS*32-1:0] cfg_pm_data
);

  // ****************************************
  // sub-blocks
  // ****************************************
  reg_if rb ();
  word_if wf ();

  axil_regs_slave u_slave (
    .clk(clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.bus)
  );

  word_fetcher u_fetch (
    .clk(clk),
    .resetn(resetn),
    .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid),
    .wf(wf.fetch)
  );

  // ****************************************
  // load sequencing
  // ****************************************
  logic start_pend_q;
  logic host_en_q;
  logic [CNT_W-1:0] cnt_q;
  logic reload_wr;

  assign reload_wr = rb.wr_en && rb.wr_addr == REG_CTRL && rb.wr_strb[0]
                     && rb.wr_data[CTRL_RELOAD_BIT];
  assign wf.start = start_pend_q && !wf.busy;
  assign host_cfg_enable = host_en_q;

  // a load is pending from reset; a reload during a load queues one more
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      start_pend_q <= 1'b1;
    else if (reload_wr)
      start_pend_q <= 1'b1;
    else if (wf.start)
      start_pend_q <= 1'b0;
  end

  // host configuration is held off until every word has been placed
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      host_en_q <= 1'b0;
    else
      host_en_q <= wf.done && !wf.busy && !start_pend_q && !wf.word_valid;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= '0;
    else if (wf.start)
      cnt_q <= '0;
    else if (wf.word_valid)
      cnt_q <= cnt_q + 4'h1;
  end

  // ****************************************
  // word store
  // ****************************************
  logic [WORD_W-1:0] word_q [NUM_WORDS];

  for (genvar i = 0; i < NUM_WORDS; i++)
  begin : g_word
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        word_q[i] <= WORD_RST;
      else if (wf.word_valid && wf.word_idx == IDX_W'(i))
        word_q[i] <= wf.word_data;
    end
  end

  // ****************************************
  // port 2 physical layer fields
  // ****************************************
  logic [WORD_W-1:0] w_phy;
  logic [WORD_W-1:0] w_misc;

  assign w_phy = word_q[IDX_PHY];
  assign w_misc = word_q[IDX_P0_MISC];

  assign cfg_p2_7c = fld(w_phy, PHY2_SRC, PHY2_W, PHY2_DST);
  assign cfg_p2_90 = fld(w_phy, PHY3_SRC, PHY3_W, PHY3_DST);
  assign cfg_p2_f0 = fld(w_phy, DEEMPH_SRC, DEEMPH_W, DEEMPH_DST);
  assign cfg_p2_78 = fld(w_phy, COMPL_SRC, COMPL_W, COMPL_DST);
  assign cfg_p2_8c = fld(w_phy, DCNT_SRC, DCNT_W, DCNT_DST);

  // ****************************************
  // port 0 slot, channel and numbering fields
  // ****************************************
  logic [31:0] p0_dsi;

  assign cfg_p0_d0 = fld(w_misc, SLOTCLK_SRC, SLOTCLK_W, SLOTCLK_DST);
  assign p0_dsi = fld(w_misc, DSI_SRC, DSI_W, DSI_DST);
  assign cfg_p0_144 = fld(w_misc, LPVC_SRC, LPVC_W, LPVC_DST);
  assign cfg_p0_cc = fld(w_misc, PORTNUM_SRC, PORTNUM_W, PORTNUM_DST);
  assign cfg_p0_154 = fld(w_misc, TCMAP_SRC, TCMAP_W, TCMAP_DST);

  // ****************************************
  // power management fields, one pair of words per port
  // ****************************************
  logic [31:0] pm_cap [NUM_PORTS];
  logic [31:0] pm_data [NUM_PORTS];

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_pm
    logic [WORD_W-1:0] w_cap;
    logic [WORD_W-1:0] w_dat;
    logic [31:0] aux, d1, d2, pme, extra;

    assign w_cap = word_q[IDX_PM_BASE + 2 * p];
    assign w_dat = word_q[IDX_PM_BASE + 2 * p + 1];
    assign aux = fld(w_cap, AUX_SRC, AUX_W, AUX_DST);
    assign d1 = fld(w_cap, D1_SRC, D1_W, D1_DST);
    assign d2 = fld(w_cap, D2_SRC, D2_W, D2_DST);
    assign pme = fld(w_cap, PME_SRC, PME_W, PME_DST);
    // only port 0 carries the device specific init flag
    assign extra = (p == 0) ? p0_dsi : 32'h0000_0000;
    assign pm_cap[p] = aux | d1 | d2 | pme | extra;
    assign pm_data[p] = fld(w_dat, PMDATA_SRC, PMDATA_W, PMDATA_DST)
                        | fld(w_cap, NOSR_SRC, NOSR_W, NOSR_DST);
    assign cfg_pm_cap[p*32 +: 32] = pm_cap[p];
    assign cfg_pm_data[p*32 +: 32] = pm_data[p];
  end

  // ****************************************
  // register decode
  // ****************************************
  // only the control register is writable; loaded fields stay read-only
  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    logic hit;
    hit = (a == REG_CTRL) || (a == REG_STATUS);
    hit = hit || (a >= REG_P2_7C && a <= REG_P0_154 && a[1:0] == 2'b00);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      hit = hit || a == REG_PM_CAP_BASE + AXI_ADDR_W'(4 * p);
      hit = hit || a == REG_PM_DATA_BASE + AXI_ADDR_W'(4 * p);
    end
    mapped = hit;
  endfunction

  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign rb.wr_ok = mapped(rb.wr_addr);
  assign rb.rd_ok = mapped(rb.rd_addr);
  assign rb.rd_data = rd_mux;
  assign status_word = (32'(wf.busy) << STAT_BUSY_BIT) | (32'(host_en_q) << STAT_DONE_BIT)
                       | (32'(cnt_q) << STAT_CNT_LSB);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rb.rd_addr)
      REG_STATUS: rd_mux = status_word;
      REG_P2_7C: rd_mux = cfg_p2_7c;
      REG_P2_90: rd_mux = cfg_p2_90;
      REG_P2_F0: rd_mux = cfg_p2_f0;
      REG_P2_78: rd_mux = cfg_p2_78;
      REG_P2_8C: rd_mux = cfg_p2_8c;
      REG_P0_D0: rd_mux = cfg_p0_d0;
      REG_P0_144: rd_mux = cfg_p0_144;
      REG_P0_CC: rd_mux = cfg_p0_cc;
      REG_P0_154: rd_mux = cfg_p0_154;
      default: rd_mux = 32'h0000_0000;
    endcase
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rb.rd_addr == REG_PM_CAP_BASE + AXI_ADDR_W'(4 * p))
        rd_mux = pm_cap[p];
      if (rb.rd_addr == REG_PM_DATA_BASE + AXI_ADDR_W'(4 * p))
        rd_mux = pm_data[p];
    end
  end

endmodule

// >>> verilog/word_fetcher.sv
// fetches the configuration memory words one after another
module word_fetcher
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  output logic mem_rd_req,
  output logic [MEM_ADDR_W-1:0] mem_rd_addr,
  input wire logic [WORD_W-1:0] mem_rd_data,
  input wire logic mem_rd_valid,
  word_if.fetch wf
);

  typedef enum logic {ST_IDLE, ST_FETCH} fetch_state_t;

  fetch_state_t state_q;
  logic [IDX_W-1:0] idx_q;
  logic [MEM_ADDR_W-1:0] addr_q;
  logic done_q;
  logic wvalid_q;
  logic [IDX_W-1:0] widx_q;
  logic [WORD_W-1:0] wdata_q;
  logic [IDX_W-1:0] idx_next;
  logic take;

  assign take = (state_q == ST_FETCH) && mem_rd_valid;
  assign idx_next = idx_q + 3'h1;
  assign mem_rd_req = (state_q == ST_FETCH);
  assign mem_rd_addr = addr_q;
  assign wf.busy = (state_q == ST_FETCH);
  assign wf.done = done_q;
  assign wf.word_valid = wvalid_q;
  assign wf.word_idx = widx_q;
  assign wf.word_data = wdata_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      addr_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (wf.start)
          begin
            state_q <= ST_FETCH;
            idx_q <= '0;
            addr_q <= WORD_ADDR_LIST[7:0];
            done_q <= 1'b0;
          end
        end
        ST_FETCH:
        begin
          if (take && idx_q == IDX_LAST)
          begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
          else if (take)
          begin
            idx_q <= idx_next;
            addr_q <= WORD_ADDR_LIST[32'(idx_next) * 8 +: 8];
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // one 16-bit word per memory address, handed on as a one-cycle pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wvalid_q <= 1'b0;
      widx_q <= '0;
      wdata_q <= WORD_RST;
    end
    else
    begin
      wvalid_q <= take;
      if (take)
      begin
        widx_q <= idx_q;
        wdata_q <= mem_rd_data;
      end
    end
  end

endmodule
